// file: nva_assertions.sv
// Checker: timing relations on the host to target link signals
`timescale 1ns/10ps
module nva_assertions #(
   parameter int FEAT_CYCLES = 10
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce_n,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd,
   input wire logic [7:0] addr,
   input wire logic [7:0] data,
   input wire logic busy,
   input wire logic chain_enable_in,
   input wire logic chain_enable_out_o,
   input wire logic chain_enable_out_oe
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic feat_q;
   logic high_q;
   logic [7:0] bcnt_q;
   ////////////////////////////////////////////////////////////////////////////////
   // Flags live until reset, as the appointment itself does
   always_ff @(posedge clk) begin
      if (rst) feat_q <= 1'h0;
      else if (cmd_valid && cmd == nva_pkg::CMD_SET_FEAT) feat_q <= 1'h1;
   end
   always_ff @(posedge clk) begin
      if (rst) high_q <= 1'h0;
      else if (chain_enable_out_oe && chain_enable_out_o) high_q <= 1'h1;
   end
   always_ff @(posedge clk) begin
      if (rst || !busy) bcnt_q <= 8'h00;
      else bcnt_q <= bcnt_q + 8'h01;
   end
   ////////////////////////////////////////////////////////////////////////////////
   property p_out_low; !feat_q && chain_enable_out_oe |-> !chain_enable_out_o; endproperty
   a_out_low: assert property (p_out_low) else $error("chain out high too early");
   property p_float; ce_n [*2] |-> !chain_enable_out_oe; endproperty
   a_float: assert property (p_float) else $error("chain out driven with ce high");
   property p_drive; !ce_n [*2] |-> chain_enable_out_oe; endproperty
   a_drive: assert property (p_drive) else $error("chain out not driven");
   property p_busy;
      cmd_valid && !ce_n && chain_enable_in && cmd == nva_pkg::CMD_SET_FEAT
         && addr == nva_pkg::FEAT_VOL_CFG |=> busy;
   endproperty
   a_busy: assert property (p_busy) else $error("no busy after appointment");
   property p_busy_len; $fell(busy) |-> bcnt_q == 8'(FEAT_CYCLES); endproperty
   a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
   // Chain out is registered from the busy counter, so it follows busy by one cycle
   property p_out_up; $fell(busy) && !ce_n |=> chain_enable_out_o; endproperty
   a_out_up: assert property (p_out_up) else $error("chain out not raised");
   property p_keep; high_q && chain_enable_out_oe |-> chain_enable_out_o; endproperty
   a_keep: assert property (p_keep) else $error("appointment lost");
   property p_idle; busy |-> !cmd_valid; endproperty
   a_idle: assert property (p_idle) else $error("command during busy");
   property p_space; cmd_valid |=> !cmd_valid [*2]; endproperty
   a_space: assert property (p_space) else $error("commands too close");
   property p_sel; cmd_valid && cmd == nva_pkg::CMD_VOL_SEL |-> !$past(ce_n); endproperty
   a_sel: assert property (p_sel) else $error("select without ce low");
endmodule

// file: nva_device.sv
// Device end: one target's chain enable, volume appointment and selection logic
`timescale 1ns/10ps
// Functional notes
// [R1] Chain out low until address appointed
// [R2] Chain out floats while chip enable high; reset drives it low instead
// [R3] Appointed target drives chain out high
// [R4] Appointment deselects, chain input then ignored
// [R5] Commands accepted only with chain high; appointed targets and parallel reset accept them with chain low
// [R6] Volume select picks matching appointed target
// [R7] Chip enable high time restores selection
// [R8] Hard reset keeps appointment and mode
// [R9] First command picks parallel or sequential
// [R10] Host waits chain delays between targets
// [R11] Host never staggers shared appointments
// [R12] Host idle during feature busy time
// [R13] Host polls ready before configuring
// [R14] Unique address; deselected until selected
// [R15] Host keeps chip enable low throughout
// [R16] Host appoints even without chain wiring
// [R17] Unselected volume deselects its units
// [R18] Appointment lost only at power on
// [R19] Host waits 100ns before volume select
// [R20] Host holds chip enable high first
// [R21] Host never broadcasts to volumes
// [R22] Host finishes init with volume select
// [R23] No select first: revert to last
// [R24] Address stored, compared on select
module nva_device #(
   parameter int unsigned FEAT_CYCLES = nva_pkg::FEAT_CYC
) (
   input wire logic clk,
   input wire logic rst,
   nva_if.device link,
   input wire logic [nva_pkg::VOL_W-1:0] own_term_vol,
   output logic selected,
   output logic appointed,
   output logic cmd_accepted,
   output logic [nva_pkg::VOL_W-1:0] volume_addr,
   output logic [7:0] last_cmd
);
   logic appointed_q;
   logic [nva_pkg::VOL_W-1:0] vol_q;
   logic [nva_pkg::VOL_W-1:0] last_vol_q;
   nva_pkg::nva_init_t init_q;
   nva_pkg::nva_sel_t sel_q;
   logic [7:0] ceh_q;
   logic [7:0] busy_q;
   logic first_q;
   logic ce_low_q;
   logic acc_q;
   logic [7:0] last_q;
   logic gate;
   logic take;
   logic is_appoint;
   logic par_rst;

   ////////////////////////////////////////////////////////////////////////////
   // Gating: appointed targets ignore the chain input
   assign gate = !link.ce_n && (appointed_q || link.chain_enable_in); // [R5] [R4]
   assign take = link.cmd_valid && !link.ce_n;
   assign is_appoint = link.cmd == nva_pkg::CMD_SET_FEAT && link.addr == nva_pkg::FEAT_VOL_CFG;
   // Parallel reset reaches every unappointed target whatever its chain input
   assign par_rst = take && !appointed_q && link.cmd == nva_pkg::CMD_RESET
      && (first_q || init_q == nva_pkg::NVA_INIT_PAR); // [R9]

   // Appointment: cleared by power-on reset only; hard reset is just a command
   always_ff @(posedge clk) begin
      if (rst) begin
         appointed_q <= 1'b0; // [R18]
         vol_q <= '0;
      end else if (take && gate && !appointed_q && is_appoint) begin
         appointed_q <= 1'b1; // [R24]
         vol_q <= link.data[nva_pkg::VOL_W-1:0];
      end
   end

   // First command after power on picks the reset style
   always_ff @(posedge clk) begin
      if (rst) begin
         init_q <= nva_pkg::NVA_INIT_NONE;
         first_q <= 1'b1;
      end else if (take && first_q) begin
         first_q <= 1'b0;
         if (link.cmd == nva_pkg::CMD_RESET) begin
            init_q <= nva_pkg::NVA_INIT_PAR; // [R9]
         end else if (link.cmd == nva_pkg::CMD_STATUS) begin
            init_q <= nva_pkg::NVA_INIT_SEQ; // [R9]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Chip enable high timer and selection state
   always_ff @(posedge clk) begin
      if (rst) begin
         ceh_q <= nva_pkg::CNT_ZERO;
         ce_low_q <= 1'b0;
      end else begin
         ce_low_q <= !link.ce_n;
         if (!link.ce_n) begin
            ceh_q <= nva_pkg::CNT_ZERO;
         end else if (ceh_q < 8'(nva_pkg::CEH_CYC)) begin
            ceh_q <= ceh_q + nva_pkg::CNT_ONE;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         sel_q <= nva_pkg::NVA_SEL_ALL;
         last_vol_q <= '0;
      end else if (take && gate && !appointed_q && is_appoint) begin
         sel_q <= nva_pkg::NVA_SEL_OFF; // [R4] [R14]
      end else if (take && appointed_q && link.cmd == nva_pkg::CMD_VOL_SEL) begin
         last_vol_q <= link.addr[nva_pkg::VOL_W-1:0];
         if (link.addr[nva_pkg::VOL_W-1:0] == vol_q) begin
            sel_q <= nva_pkg::NVA_SEL_ON; // [R6] [R24]
         end else begin
            sel_q <= nva_pkg::NVA_SEL_OFF; // [R17]
         end
      end else if (appointed_q && link.ce_n && ceh_q >= 8'(nva_pkg::CEH_CYC)) begin
         // Revert to last named volume; no select needed to resume it
         sel_q <= (last_vol_q == vol_q) ? nva_pkg::NVA_SEL_ON : nva_pkg::NVA_SEL_OFF; // [R7] [R23]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Command acceptance; sequential reset only with chain high
   always_ff @(posedge clk) begin
      if (rst) begin
         acc_q <= 1'b0;
         last_q <= 8'h00;
      end else begin
         acc_q <= par_rst || take && gate && (appointed_q ? (sel_q == nva_pkg::NVA_SEL_ON
            || link.cmd == nva_pkg::CMD_VOL_SEL) : 1'b1); // [R5] [R9]
         if (take && gate) begin
            last_q <= link.cmd; // [R8]
         end
      end
   end

   // Busy for feature busy time after an appointment
   always_ff @(posedge clk) begin
      if (rst) begin
         busy_q <= nva_pkg::CNT_ZERO;
      end else if (take && gate && !appointed_q && is_appoint) begin
         busy_q <= 8'(FEAT_CYCLES);
      end else if (busy_q != nva_pkg::CNT_ZERO) begin
         busy_q <= busy_q - nva_pkg::CNT_ONE;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Chain output pin, registered
   logic eno_q;
   logic eno_oe_q;
   always_ff @(posedge clk) begin
      if (rst) begin
         eno_q <= 1'b0; // [R1]
         eno_oe_q <= 1'b1;
      end else begin
         eno_oe_q <= !link.ce_n; // [R2]
         eno_q <= appointed_q && busy_q == nva_pkg::CNT_ZERO && !link.ce_n; // [R1] [R3]
      end
   end

   logic busy_o_q;
   always_ff @(posedge clk) begin
      if (rst) begin
         busy_o_q <= 1'b0;
      end else begin
         busy_o_q <= busy_q > nva_pkg::CNT_ONE || (take && gate && !appointed_q && is_appoint);
      end
   end

   assign link.chain_enable_out_o = eno_q;
   assign link.chain_enable_out_oe = eno_oe_q;
   assign link.busy = busy_o_q;
   assign selected = (sel_q == nva_pkg::NVA_SEL_ON);
   assign appointed = appointed_q;
   assign cmd_accepted = acc_q;
   assign volume_addr = vol_q;
   assign last_cmd = last_q;
   logic unused_ok;
   assign unused_ok = ^{own_term_vol, init_q, ce_low_q};
endmodule

// file: nva_host.sv
// Host end: issues commands with the waits that volume addressing requires
`timescale 1ns/10ps
module nva_host (
   input wire logic clk,
   input wire logic rst,
   nva_if.host link,
   input wire logic req,
   input wire logic [7:0] req_cmd,
   input wire logic [7:0] req_addr,
   input wire logic [7:0] req_data,
   input wire logic req_ce_n,
   input wire logic chain_in_drive,
   output logic req_ready
);
   logic ce_n_q;
   logic valid_q;
   logic [7:0] cmd_q;
   logic [7:0] addr_q;
   logic [7:0] data_q;
   logic [7:0] wait_q;
   logic [7:0] low_q;
   logic ready_q;
   logic eni_q;

   ////////////////////////////////////////////////////////////////////////////
   // Chip enable and time spent low
   always_ff @(posedge clk) begin
      if (rst) begin
         ce_n_q <= 1'b1;
         low_q <= nva_pkg::CNT_ZERO;
         eni_q <= 1'b0;
      end else begin
         eni_q <= chain_in_drive;
         if (wait_q == nva_pkg::CNT_ZERO && !valid_q) begin
            ce_n_q <= req_ce_n; // [R15] [R20]
         end
         if (ce_n_q) begin
            low_q <= nva_pkg::CNT_ZERO;
         end else if (low_q < 8'(nva_pkg::CE_SEL_CYC)) begin
            low_q <= low_q + nva_pkg::CNT_ONE;
         end
      end
   end

   // One command at a time; set feature waits feature busy, others chain delays
   always_ff @(posedge clk) begin
      if (rst) begin
         valid_q <= 1'b0;
         cmd_q <= 8'h00;
         addr_q <= 8'h00;
         data_q <= 8'h00;
         wait_q <= nva_pkg::CNT_ZERO;
      end else if (valid_q) begin
         valid_q <= 1'b0; // [R21]
      end else if (wait_q != nva_pkg::CNT_ZERO || link.busy) begin
         wait_q <= (wait_q == nva_pkg::CNT_ZERO) ? wait_q : wait_q - nva_pkg::CNT_ONE; // [R12]
      end else if (req && !ce_n_q
            && (req_cmd != nva_pkg::CMD_VOL_SEL || low_q >= 8'(nva_pkg::CE_SEL_CYC))) begin
         valid_q <= 1'b1; // [R19] [R22]
         cmd_q <= req_cmd;
         addr_q <= req_addr;
         data_q <= req_data;
         wait_q <= (req_cmd == nva_pkg::CMD_SET_FEAT) ? 8'(nva_pkg::FEAT_CYC)
            : 8'(nva_pkg::CHAIN_CYC); // [R10] [R11]
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ready_q <= 1'b0;
      end else begin
         ready_q <= !valid_q && wait_q == nva_pkg::CNT_ZERO && !link.busy && !ce_n_q;
      end
   end

   assign link.ce_n = ce_n_q;
   assign link.cmd_valid = valid_q;
   assign link.cmd = cmd_q;
   assign link.addr = addr_q;
   assign link.data = data_q;
   assign link.chain_enable_in = eni_q;
   assign req_ready = ready_q;
endmodule

// file: nva_if.sv
// Interface: host command strobe, chip enable and chain pins between host and target
`timescale 1ns/10ps
interface nva_if;
   logic ce_n;
   logic cmd_valid;
   logic [7:0] cmd;
   logic [7:0] addr;
   logic [7:0] data;
   logic busy;
   logic chain_enable_in;
   logic chain_enable_out_o;
   logic chain_enable_out_oe;
   modport device (
      input ce_n, cmd_valid, cmd, addr, data, chain_enable_in,
      output busy, chain_enable_out_o, chain_enable_out_oe
   );
   modport host (
      output ce_n, cmd_valid, cmd, addr, data, chain_enable_in,
      input busy, chain_enable_out_o, chain_enable_out_oe
   );
endinterface

// file: nva_pkg.sv
// Package: command codes, timing constants and selection states for volume addressing
package nva_pkg;
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam logic [7:0] CMD_RESET = 8'hff;
   localparam logic [7:0] CMD_HARD_RESET = 8'hfd;
   localparam logic [7:0] CMD_STATUS = 8'h70;
   localparam logic [7:0] CMD_SET_FEAT = 8'hef;
   localparam logic [7:0] CMD_VOL_SEL = 8'he1;
   localparam logic [7:0] FEAT_VOL_CFG = 8'h58;
   localparam int unsigned VOL_W = 4;
   // Chip enable high time, ns; least time rounds up
   localparam int unsigned CEH_NS = 100;
   localparam int unsigned CEH_CYC = (CEH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Chip enable low before volume select, ns
   localparam int unsigned CE_SEL_NS = 100;
   localparam int unsigned CE_SEL_CYC = (CE_SEL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Feature busy time, ns
   localparam int unsigned FEAT_NS = 1000;
   localparam int unsigned FEAT_CYC = (FEAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Chain out plus chain in delay plus wiring, ns
   localparam int unsigned CHAIN_NS = 300;
   localparam int unsigned CHAIN_CYC = (CHAIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] CNT_ZERO = 8'h00;
   localparam logic [7:0] CNT_ONE = 8'h01;
   typedef enum logic [1:0] {
      NVA_INIT_NONE = 2'b00,
      NVA_INIT_PAR = 2'b01,
      NVA_INIT_SEQ = 2'b10
   } nva_init_t;
   typedef enum logic [1:0] {
      NVA_SEL_ALL = 2'b00,
      NVA_SEL_ON = 2'b01,
      NVA_SEL_OFF = 2'b10
   } nva_sel_t;
endpackage

// file: tb_top.sv
// Testbench: host and target joined by the link, table driven command checks
`timescale 1ns/10ps
module tb_top;
   localparam int FEAT = 4;
   typedef struct packed {
      logic [7:0] cmd;
      logic [7:0] adr;
      logic chain;
      logic acc;
      logic sel;
      logic appt;
   } nva_row_t;
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic req = 1'h0;
   logic [7:0] req_cmd = 8'h00;
   logic [7:0] req_addr = 8'h00;
   logic req_ce_n = 1'h1;
   logic chain = 1'h0;
   logic req_ready, selected, appointed, cmd_accepted, got;
   logic [3:0] volume_addr;
   logic [7:0] last_cmd;
   int n_errors = 0;
   int comparisons = 0;
   nva_row_t rows [10];
   nva_if link ();
   always #50 clk = ~clk;
   nva_device #(.FEAT_CYCLES(FEAT)) nva_device_inst (.clk(clk), .rst(rst), .link(link),
      .own_term_vol(4'h0), .selected(selected), .appointed(appointed),
      .cmd_accepted(cmd_accepted), .volume_addr(volume_addr), .last_cmd(last_cmd));
   nva_host nva_host_inst (.clk(clk), .rst(rst), .link(link), .req(req), .req_cmd(req_cmd),
      .req_addr(req_addr), .req_data(8'h05), .req_ce_n(req_ce_n), .chain_in_drive(chain),
      .req_ready(req_ready));
   nva_assertions #(.FEAT_CYCLES(FEAT)) nva_assertions_inst (.clk(clk), .rst(rst),
      .ce_n(link.ce_n), .cmd_valid(link.cmd_valid), .cmd(link.cmd), .addr(link.addr),
      .data(link.data), .busy(link.busy), .chain_enable_in(link.chain_enable_in),
      .chain_enable_out_o(link.chain_enable_out_o),
      .chain_enable_out_oe(link.chain_enable_out_oe));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      comparisons++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic end_sim;
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Acceptance is a one-cycle pulse, so it is caught over a window
   task automatic send(input logic [7:0] c, input logic [7:0] a);
      int i = 0;
      while (req_ready !== 1'h1 && i < 100) begin
         @(posedge clk);
         #5;
         i++;
      end
      if (i == 100) n_errors++;
      req_cmd = c;
      req_addr = a;
      req = 1'h1;
      @(posedge clk);
      #5;
      req = 1'h0;
      got = 1'h0;
      repeat (16) begin
         @(posedge clk);
         #5;
         if (cmd_accepted === 1'h1) got = 1'h1;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      rows[0] = {8'h70, 8'h00, 4'h0};
      rows[1] = {8'hff, 8'h00, 4'h0};
      rows[2] = {8'hff, 8'h00, 4'hc};
      rows[3] = {8'hef, 8'h58, 4'hd};
      rows[4] = {8'h70, 8'h00, 4'h1};
      rows[5] = {8'he1, 8'h05, 4'h7};
      rows[6] = {8'hfd, 8'h00, 4'h7};
      rows[7] = {8'h70, 8'h00, 4'h7};
      rows[8] = {8'he1, 8'h03, 4'h5};
      rows[9] = {8'h70, 8'h00, 4'h1};
      repeat (3) @(posedge clk);
      #5;
      chk({6'h00, link.chain_enable_out_oe, link.chain_enable_out_o}, 8'h02);
      rst = 1'h0;
      req_ce_n = 1'h0;
      repeat (4) @(posedge clk);
      #5;
      for (int k = 0; k < 10; k++) begin
         chain = rows[k].chain;
         repeat (2) @(posedge clk);
         #5;
         send(rows[k].cmd, rows[k].adr);
         chk({7'h00, got}, {7'h00, rows[k].acc});
         chk({7'h00, selected}, {7'h00, rows[k].sel});
         chk({7'h00, appointed}, {7'h00, rows[k].appt});
      end
      chk({4'h0, volume_addr}, 8'h05);
      send(nva_pkg::CMD_VOL_SEL, 8'h05);
      req_ce_n = 1'h1;
      repeat (4) @(posedge clk);
      #5;
      chk({7'h00, link.chain_enable_out_oe}, 8'h00);
      req_ce_n = 1'h0;
      repeat (4) @(posedge clk);
      #5;
      chk({7'h00, selected}, 8'h01);
      chk({6'h00, link.chain_enable_out_oe, link.chain_enable_out_o}, 8'h03);
      rst = 1'h1;
      repeat (3) @(posedge clk);
      #5;
      chk({6'h00, appointed, selected}, 8'h00);
      // Reset first after power on: accepted even with the chain input low
      rst = 1'h0;
      chain = 1'h0;
      repeat (4) @(posedge clk);
      #5;
      send(nva_pkg::CMD_RESET, 8'h00);
      chk({7'h00, got}, 8'h01);
      end_sim;
   end
   initial begin
      #2000000;
      n_errors++;
      end_sim;
   end
endmodule
